// *** tb/pcu_link_asserts.sv ***
`default_nettype none
module pcu_link_asserts (
    input wire logic core_clk,            // system clock
    input wire logic rstn,                // async reset, low
    input wire logic serialDevToPeer,     // device tx line
    input wire logic master_clear,        // sync clear, high
    input wire logic rx_output_disable,   // char outputs off
    input wire logic flag_output_disable, // flag outputs off
    input wire logic rx_flag_clear_n,     // valid clear, low
    input wire logic rxCharOutOe,         // char drive enable
    input wire logic flagOe,              // flag drive enable
    input wire logic parityErrorFlag,     // parity error
    input wire logic framingErrorFlag,    // framing error
    input wire logic overrunFlag,         // overrun
    input wire logic rxCharValid,         // data received
    input wire logic txHoldingEmpty,      // holding empty
    input wire logic txShiftEmpty         // shifter empty
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // output enables follow the disable pins at once
    char_tristate_a: assert property (rx_output_disable
        |-> !rxCharOutOe)
        else $error("char outputs driven while disabled");
    flag_tristate_a: assert property (flag_output_disable |-> !flagOe)
        else $error("flag outputs driven while disabled");
    // held master clear zeroes flags and idles the line
    mclr_clears_a: assert property (master_clear ##1 master_clear
        ##1 master_clear |-> !rxCharValid && !parityErrorFlag
        && !framingErrorFlag && !overrunFlag && serialDevToPeer)
        else $error("master clear left a flag or the line low");
    valid_clear_a: assert property (!rx_flag_clear_n ##1
        !rx_flag_clear_n ##1 !rx_flag_clear_n |-> !rxCharValid)
        else $error("valid flag survived the clear input");
    overrun_cause_a: assert property ($rose(overrunFlag)
        |-> $past(rxCharValid))
        else $error("overrun without a pending character");
    // an idle shifter leaves the line at mark
    idle_mark_a: assert property (txShiftEmpty |-> serialDevToPeer)
        else $error("line low while shifter empty");
    hold_to_shift_a: assert property ($fell(txHoldingEmpty)
        && $past(txShiftEmpty) |-> ##[1:3] txHoldingEmpty)
        else $error("holding register not passed to idle shifter");
    start_bit_a: assert property ($fell(serialDevToPeer)
        |-> (!serialDevToPeer)[*8])
        else $error("start bit too short");
    busy_flag_a: assert property ($fell(serialDevToPeer)
        |-> !txShiftEmpty)
        else $error("shifter empty during a frame");
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0, rstn = 1'b0, mclr = 1'b0;
    logic        rxOd = 1'b0, flagOd = 1'b0, clearN = 1'b1, loadN = 1'b1;
    logic        cfgLoad2 = 1'b0, parOff = 1'b1, stopSel = 1'b0;
    logic        lenLo = 1'b1, lenHi = 1'b1, evenSel = 1'b0;
    logic        sendValid = 1'b0, prevV1 = 1'b0, prevV2 = 1'b0;
    logic [7:0]  txChar = 8'h00, sendData = 8'h00, rxCharOut1, rxCharOut2;
    logic [7:0]  recvData, rnd;
    logic [1:0]  tickCnt = 2'h0;
    logic [31:0] lfsrQ = 32'ha8d5;
    logic        pe1, fe1, ov1, v1, the1, tse1, coe1, foe1;
    logic        pe2, fe2, ov2, v2, the2, tse2, coe2, foe2;
    logic        sendReady, recvValid;
    logic        prevO1 = 1'b0, prevO2 = 1'b0;
    logic [10:0] got1, got2;
    logic [2:0]  txs2;
    logic [10:0] expPeer[$], expDev1[$], expDev2[$];
    int          miscompares = 0, cmp_count = 0;
    pcu_if       line1();
    pcu_if       line2();

    // clock and 16x rate pins, one tick every four cycles
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) tickCnt <= tickCnt + 2'h1;
    initial line2.serialPeerToDev = 1'b1;

    pcu_device i_pcu_device (.core_clk(core_clk), .rstn(rstn), .line(line1),
        .master_clear(mclr), .rx_sample_clock(tickCnt[1]),
        .tx_shift_clock(tickCnt[1]), .rx_output_disable(rxOd),
        .flag_output_disable(flagOd), .rx_flag_clear_n(clearN),
        .tx_holding_load_n(loadN), .tx_char_in(txChar),
        .config_latch_load(1'b0), .parity_off(parOff),
        .stop_length_select(stopSel), .length_select_low(lenLo),
        .length_select_high(lenHi), .even_parity_select(evenSel),
        .rxCharOut(rxCharOut1), .rxCharOutOe(coe1), .parityErrorFlag(pe1),
        .framingErrorFlag(fe1), .overrunFlag(ov1), .rxCharValid(v1),
        .txHoldingEmpty(the1), .flagOe(foe1), .txShiftEmpty(tse1));
    pcu_device i_pcu_device2 (.core_clk(core_clk), .rstn(rstn), .line(line2),
        .master_clear(mclr), .rx_sample_clock(tickCnt[1]),
        .tx_shift_clock(tickCnt[1]), .rx_output_disable(rxOd),
        .flag_output_disable(flagOd), .rx_flag_clear_n(clearN),
        .tx_holding_load_n(loadN), .tx_char_in(txChar),
        .config_latch_load(cfgLoad2), .parity_off(parOff),
        .stop_length_select(stopSel), .length_select_low(lenLo),
        .length_select_high(lenHi), .even_parity_select(evenSel),
        .rxCharOut(rxCharOut2), .rxCharOutOe(coe2), .parityErrorFlag(pe2),
        .framingErrorFlag(fe2), .overrunFlag(ov2), .rxCharValid(v2),
        .txHoldingEmpty(the2), .flagOe(foe2), .txShiftEmpty(tse2));
    pcu_peer i_pcu_peer (.core_clk(core_clk), .rstn(rstn), .line(line1),
        .bitTick(tickCnt == 2'h0), .sendValid(sendValid),
        .sendData(sendData), .sendReady(sendReady), .recvData(recvData),
        .recvValid(recvValid));
    pcu_link_asserts i_pcu_link_asserts (.core_clk(core_clk), .rstn(rstn),
        .serialDevToPeer(line1.serialDevToPeer), .master_clear(mclr),
        .rx_output_disable(rxOd), .flag_output_disable(flagOd),
        .rx_flag_clear_n(clearN), .rxCharOutOe(coe1), .flagOe(foe1),
        .parityErrorFlag(pe1), .framingErrorFlag(fe1), .overrunFlag(ov1),
        .rxCharValid(v1), .txHoldingEmpty(the1), .txShiftEmpty(tse1));

    task automatic check(string name, logic [10:0] e, logic [10:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic pop_check(string name, ref logic [10:0] q[$],
                             input logic [10:0] g);
        if (q.size() == 0) begin
            miscompares++;
            $display("[ERR] %s expected none seen %h", name, g);
        end else check(name, q.pop_front(), g);
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // fixed-seed pseudo random byte source
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic next_rnd;
        lfsrQ = lfsr_next(lfsrQ);
        rnd = lfsrQ[7:0];
    endtask
    task automatic peer_send(logic [7:0] d, logic ovr);
        int n;
        n = 0;
        expDev1.push_back({2'b00, ovr, d});
        @(posedge core_clk);
        sendValid <= 1'b1;
        sendData <= d;
        do @(posedge core_clk); while (sendReady !== 1'b1 && n++ < 2000);
        sendValid <= 1'b0;
    endtask
    // load strobe low latches, rising edge queues the character
    task automatic dev_load(logic [7:0] d);
        int n;
        n = 0;
        expPeer.push_back({3'h0, d});
        @(posedge core_clk);
        txChar <= d;
        loadN <= 1'b0;
        repeat (4) @(posedge core_clk);
        loadN <= 1'b1;
        repeat (8) @(posedge core_clk);
        while (the1 !== 1'b1 && n++ < 2000) @(posedge core_clk);
    endtask
    task automatic send_raw(logic [10:0] bits);
        for (int i = 0; i < 11; i++) begin
            line2.serialPeerToDev <= bits[i];
            repeat (64) @(posedge core_clk);
        end
        line2.serialPeerToDev <= 1'b1;
        repeat (64) @(posedge core_clk);
    endtask
    task automatic wire_check(logic [10:0] e);
        int n;
        n = 0;
        while (line2.serialDevToPeer !== 1'b0 && n++ < 3000)
            @(posedge core_clk);
        repeat (32) @(posedge core_clk);
        for (int i = 0; i < 11; i++) begin
            check("wire", 11'(e[i]), 11'(line2.serialDevToPeer));
            repeat (64) @(posedge core_clk);
        end
    endtask
    task automatic drain;
        int n;
        n = 0;
        while (expPeer.size() + expDev1.size() + expDev2.size() != 0
               && n++ < 4000) @(posedge core_clk);
        check("queues", 11'h0,
              11'(expPeer.size() + expDev1.size() + expDev2.size()));
    endtask

    // flag and character bundles as the monitor compares them; tx flags and line for mclr_tx
    assign got1 = {pe1, fe1, ov1, rxCharOut1};
    assign got2 = {pe2, fe2, ov2, rxCharOut2};
    assign txs2 = {the2, tse2, line2.serialDevToPeer};

    // result monitor: pairs each arriving result with the oldest note;
    // a character landing on a held valid shows only as a new overrun
    always @(posedge core_clk) begin
        prevV1 <= v1;
        prevV2 <= v2;
        prevO1 <= ov1;
        prevO2 <= ov2;
        if (recvValid === 1'b1)
            pop_check("peer", expPeer, {3'h0, recvData});
        if ((v1 === 1'b1 && prevV1 === 1'b0) ||
            (ov1 === 1'b1 && prevO1 === 1'b0))
            pop_check("dev1", expDev1, got1);
        if ((v2 === 1'b1 && prevV2 === 1'b0) ||
            (ov2 === 1'b1 && prevO2 === 1'b0))
            pop_check("dev2", expDev2, got2);
    end
    // watchdog
    initial begin
        repeat (40000) @(posedge core_clk);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        // second device: seven bits, even parity, two stops
        {cfgLoad2, parOff, stopSel} <= 3'b101;
        {lenLo, lenHi, evenSel} <= 3'b011;
        repeat (6) @(posedge core_clk);
        cfgLoad2 <= 1'b0;
        @(posedge core_clk);
        {parOff, lenLo, lenHi} <= 3'b111;
        @(negedge core_clk);
        check("oe_on", 11'h3, {9'h0, coe1, foe1});
        @(posedge core_clk);
        {rxOd, flagOd} <= 2'b11;
        @(negedge core_clk);
        check("oe_off", 11'h0, {7'h0, coe1, foe1, coe2, foe2});
        @(posedge core_clk);
        {rxOd, flagOd} <= 2'b00;
        next_rnd();
        peer_send(rnd, 1'b0);
        next_rnd();
        peer_send(rnd, 1'b1);
        drain();
        next_rnd();
        fork
            begin
                dev_load(8'hc5);
                dev_load(rnd);
            end
            wire_check({3'b111, 7'h45, 1'b0});
        join
        drain();
        @(posedge core_clk);
        clearN <= 1'b0;
        repeat (5) @(posedge core_clk);
        clearN <= 1'b1;
        expDev2.push_back({3'b110, 8'h2a});
        send_raw({3'b100, 7'h2a, 1'b0});
        expDev2.push_back({3'b001, 8'h15});
        send_raw({3'b111, 7'h15, 1'b0});
        drain();
        @(posedge core_clk);
        clearN <= 1'b0;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        check("clear", 11'h0, {9'h0, v1, v2});
        @(posedge core_clk);
        clearN <= 1'b1;
        mclr <= 1'b1;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        check("mclr_flags", 11'h0, {7'h0, got2[10:8], v2});
        check("mclr_tx", 11'h7, {8'h0, txs2});
        @(posedge core_clk);
        mclr <= 1'b0;
        // second device: five bits, no parity
        @(posedge core_clk);
        {cfgLoad2, parOff, stopSel, lenLo, lenHi} <= 5'b11100;
        repeat (4) @(posedge core_clk);
        cfgLoad2 <= 1'b0;
        expDev2.push_back({3'b000, 8'h13});
        send_raw({5'h1f, 5'h13, 1'b0});
        drain();
        repeat (4) @(posedge core_clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** verilog/pcu_device.sv ***
// What this block does
// - rx_output_disable tri-states received character
// - short characters sit right-justified
// - parity error on mismatch, low if off
// - framing error when first stop low
// - overrun when valid still set
// - flag_output_disable tri-states status flags
// - receive sample clock is sixteen times rate
// - low clear input drops character valid
// - character valid set with buffer transfer
// - master clear zeroes flags, line high
// - holding empty once passed to shifter
// - low load latches transmit inputs
// - load rising edge starts, waits if busy
// - shift empty after all stop bits
// - start, data, parity if on, then stop bits
// - unused high transmit inputs ignored
// - high config load captures format
// - parity off disables generate and check
// - stop select gives 1.5 or 2
// - two length bits select 5 to 8
// - even select high gives even parity
// - transmit shift clock is sixteen times rate
`default_nettype none
module pcu_device (
    input  wire logic       core_clk,          // system clock
    input  wire logic       rstn,              // async reset, low
    pcu_if.device           line,              // serial link
    input  wire logic       master_clear,      // synchronous clear, high
    input  wire logic       rx_sample_clock,   // 16x rx clock pin
    input  wire logic       tx_shift_clock,    // 16x tx clock pin
    input  wire logic       rx_output_disable, // char outputs off
    input  wire logic       flag_output_disable, // flag outputs off
    input  wire logic       rx_flag_clear_n,   // clears valid, low
    input  wire logic       tx_holding_load_n, // holding load, low
    input  wire logic [7:0] tx_char_in,        // transmit character
    input  wire logic       config_latch_load, // format load, high
    input  wire logic       parity_off,        // no parity
    input  wire logic       stop_length_select, // longer stop
    input  wire logic       length_select_low, // length bit 0
    input  wire logic       length_select_high, // length bit 1
    input  wire logic       even_parity_select, // even parity
    output logic [7:0]      rxCharOut,         // received char
    output logic            rxCharOutOe,       // char drive enable
    output logic            parityErrorFlag,   // parity error
    output logic            framingErrorFlag,  // framing error
    output logic            overrunFlag,       // overrun
    output logic            rxCharValid,       // data received
    output logic            txHoldingEmpty,    // holding empty
    output logic            flagOe,            // flag drive enable
    output logic            txShiftEmpty       // shifter empty
);
    logic [1:0] rxClkSync_q, txClkSync_q, rxInSync_q; // two-stage syncs
    logic       rxClkOld_q, txClkOld_q;
    logic       loadSync1_q, loadSync2_q, loadOld_q;
    logic       rxTick, txTick, loadRise;
    logic       parOff_q, stopSel_q, evenPar_q;
    logic [1:0] lenSel_q;
    logic [3:0] charLen;
    logic [7:0] lenMask;
    logic [7:0] txHold_q;
    logic       holdFull_q;

    // synchronisers, first stage only feeds second
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rxClkSync_q <= 2'h0;
            txClkSync_q <= 2'h0;
            rxInSync_q  <= 2'h3;
            loadSync1_q <= 1'h1;
            loadSync2_q <= 1'h1;
            rxClkOld_q  <= 1'h0;
            txClkOld_q  <= 1'h0;
            loadOld_q   <= 1'h1;
        end else begin
            rxClkSync_q <= {rxClkSync_q[0], rx_sample_clock};
            txClkSync_q <= {txClkSync_q[0], tx_shift_clock};
            rxInSync_q  <= {rxInSync_q[0], line.serialPeerToDev};
            loadSync1_q <= tx_holding_load_n;
            loadSync2_q <= loadSync1_q;
            rxClkOld_q  <= rxClkSync_q[1];
            txClkOld_q  <= txClkSync_q[1];
            loadOld_q   <= loadSync2_q;
        end
    end
    assign rxTick   = rxClkSync_q[1] & ~rxClkOld_q;
    assign txTick   = txClkSync_q[1] & ~txClkOld_q;
    assign loadRise = loadSync2_q & ~loadOld_q;

    // format register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            parOff_q  <= 1'h1;
            stopSel_q <= 1'h0;
            evenPar_q <= 1'h0;
            lenSel_q  <= 2'h3;
        end else if (config_latch_load) begin
            parOff_q  <= parity_off;
            stopSel_q <= stop_length_select;
            evenPar_q <= even_parity_select;
            lenSel_q  <= {length_select_high, length_select_low};
        end
    end
    assign charLen = pcu_pkg::LEN5 + {2'h0, lenSel_q};
    assign lenMask = 8'hff >> (4'h8 - charLen);

    // ---------------- transmitter ----------------
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
    } pcu_tx_e;
    pcu_tx_e    txState_q;
    logic [7:0] txShift_q;
    logic [4:0] txCnt_q, stopLen;
    logic [3:0] txBit_q;
    logic       txPar_q, txLine_q;
    logic       stopLong;

    assign stopLong = stopSel_q && (lenSel_q != 2'h0);
    assign stopLen  = !stopSel_q ? pcu_pkg::FULL :
                      stopLong ? 5'(2 * pcu_pkg::OVS) :
                      pcu_pkg::HALF_STOP;

    // holding register, latched while load is low
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            txHold_q   <= pcu_pkg::IDLE_BYTE;
            holdFull_q <= 1'h0;
        end else if (master_clear) begin
            holdFull_q <= 1'h0;
        end else begin
            if (!loadSync2_q)
                txHold_q <= tx_char_in & lenMask;
            if (loadRise)
                holdFull_q <= 1'h1;
            else if (txState_q == TX_IDLE && holdFull_q)
                holdFull_q <= 1'h0;
        end
    end

    // transmit sequencer on 16x ticks
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            txState_q <= TX_IDLE;
            txShift_q <= pcu_pkg::IDLE_BYTE;
            txCnt_q   <= 5'h0;
            txBit_q   <= 4'h0;
            txPar_q   <= 1'h0;
            txLine_q  <= 1'h1;
        end else if (master_clear) begin
            txState_q <= TX_IDLE;
            txLine_q  <= 1'h1;
        end else begin
            unique case (txState_q)
                TX_IDLE: begin
                    txLine_q <= 1'h1;
                    if (holdFull_q) begin
                        txShift_q <= txHold_q;
                        txPar_q   <= ~evenPar_q ^ (^txHold_q);
                        txState_q <= TX_START;
                        txCnt_q   <= 5'h0;
                    end
                end
                TX_START: if (txTick) begin
                    txLine_q <= 1'h0;
                    txCnt_q  <= txCnt_q + 5'h1;
                    if (txCnt_q == pcu_pkg::FULL - 5'h1) begin
                        txState_q <= TX_DATA;
                        txCnt_q   <= 5'h0;
                        txBit_q   <= 4'h0;
                    end
                end
                TX_DATA: if (txTick) begin
                    txLine_q <= txShift_q[0];
                    txCnt_q  <= txCnt_q + 5'h1;
                    if (txCnt_q == pcu_pkg::FULL - 5'h1) begin
                        txCnt_q   <= 5'h0;
                        txShift_q <= txShift_q >> 1;
                        txBit_q   <= txBit_q + 4'h1;
                        if (txBit_q == charLen - 4'h1)
                            txState_q <= parOff_q ? TX_STOP : TX_PAR;
                    end
                end
                TX_PAR: if (txTick) begin
                    txLine_q <= txPar_q;
                    txCnt_q  <= txCnt_q + 5'h1;
                    if (txCnt_q == pcu_pkg::FULL - 5'h1) begin
                        txCnt_q   <= 5'h0;
                        txState_q <= TX_STOP;
                    end
                end
                TX_STOP: if (txTick) begin
                    txLine_q <= 1'h1;
                    txCnt_q  <= txCnt_q + 5'h1;
                    if (txCnt_q == stopLen - 5'h1)
                        txState_q <= TX_IDLE;
                end
            endcase
        end
    end
    assign line.serialDevToPeer = txLine_q;
    assign txShiftEmpty = (txState_q == TX_IDLE) && !holdFull_q;
    assign txHoldingEmpty = !holdFull_q;

    // ---------------- receiver ----------------
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} pcu_rx_e;
    pcu_rx_e    rxState_q;
    logic [4:0] rxCnt_q;
    logic [3:0] rxBit_q, rxTotal;
    logic [8:0] rxShift_q;
    logic       rxPrev_q, rxIn;
    logic [7:0] rxChar;
    logic       rxParGot, rxDone;

    assign rxIn    = rxInSync_q[1];
    assign rxTotal = charLen + {3'h0, ~parOff_q};
    assign rxDone  = rxState_q == RX_BITS && rxTick &&
                     rxCnt_q == pcu_pkg::FULL - 5'h1 && rxBit_q == rxTotal;

    // start detect and centre sampling
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rxState_q <= RX_IDLE;
            rxCnt_q   <= 5'h0;
            rxBit_q   <= 4'h0;
            rxShift_q <= 9'h0;
            rxPrev_q  <= 1'h1;
        end else if (master_clear) begin
            rxState_q <= RX_IDLE;
            rxPrev_q  <= 1'h1;
        end else begin
            rxPrev_q <= rxIn;
            unique case (rxState_q)
                RX_IDLE: if (rxPrev_q && !rxIn) begin
                    rxState_q <= RX_START;
                    rxCnt_q   <= 5'h0;
                end
                RX_START: if (rxTick) begin
                    rxCnt_q <= rxCnt_q + 5'h1;
                    if (rxCnt_q == pcu_pkg::MID - 5'h1) begin
                        rxCnt_q   <= 5'h0;
                        rxBit_q   <= 4'h0;
                        rxState_q <= rxIn ? RX_IDLE : RX_BITS;
                    end
                end
                RX_BITS: if (rxTick) begin
                    rxCnt_q <= rxCnt_q + 5'h1;
                    if (rxCnt_q == pcu_pkg::FULL - 5'h1) begin
                        rxCnt_q <= 5'h0;
                        rxBit_q <= rxBit_q + 4'h1;
                        if (rxBit_q == rxTotal)
                            rxState_q <= RX_IDLE;
                        else
                            rxShift_q[rxBit_q] <= rxIn;
                    end
                end
                default: rxState_q <= RX_IDLE;
            endcase
        end
    end
    assign rxChar   = rxShift_q[7:0] & lenMask;
    assign rxParGot = rxShift_q[charLen];

    // receive buffer and flags; set wins over clear
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rxCharOut        <= pcu_pkg::IDLE_BYTE;
            rxCharValid      <= 1'h0;
            parityErrorFlag  <= 1'h0;
            framingErrorFlag <= 1'h0;
            overrunFlag      <= 1'h0;
        end else if (master_clear) begin
            rxCharValid      <= 1'h0;
            parityErrorFlag  <= 1'h0;
            framingErrorFlag <= 1'h0;
            overrunFlag      <= 1'h0;
        end else if (rxDone) begin
            rxCharOut        <= rxChar;
            rxCharValid      <= 1'h1;
            overrunFlag      <= rxCharValid;
            framingErrorFlag <= !rxIn;
            parityErrorFlag  <= !parOff_q &&
                (rxParGot != (~evenPar_q ^ (^rxChar)));
        end else if (!rx_flag_clear_n) begin
            rxCharValid <= 1'h0;
        end
    end

    assign rxCharOutOe = !rx_output_disable;
    assign flagOe      = !flag_output_disable;
endmodule
`default_nettype wire

// *** verilog/pcu_if.sv ***
`default_nettype none
interface pcu_if;
    logic serialDevToPeer; // device transmit line
    logic serialPeerToDev; // device receive line
    modport device (output serialDevToPeer, input serialPeerToDev);
    modport peer   (input serialDevToPeer, output serialPeerToDev);
endinterface
`default_nettype wire

// *** verilog/pcu_peer.sv ***
`default_nettype none
module pcu_peer (
    input  wire logic       core_clk,     // system clock
    input  wire logic       rstn,         // async reset, low
    pcu_if.peer             line,         // serial link
    input  wire logic       bitTick,      // 16x rate enable
    input  wire logic       sendValid,    // send request
    input  wire logic [7:0] sendData,     // 8N1 byte to send
    output logic            sendReady,    // idle, may send
    output logic [7:0]      recvData,     // received byte
    output logic            recvValid     // one-cycle pulse
);
    logic [3:0] txBit_q, rxBit_q;
    logic [3:0] txCnt_q, rxCnt_q;
    logic [9:0] txFrame_q;
    logic [7:0] rxShift_q;
    logic       txBusy_q, rxBusy_q;
    logic [1:0] rxSync_q;

    // sender, 8 data, no parity, one stop
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            txBusy_q  <= 1'h0;
            txFrame_q <= 10'h3ff;
            txBit_q   <= 4'h0;
            txCnt_q   <= 4'h0;
        end else if (!txBusy_q) begin
            if (sendValid) begin
                txBusy_q  <= 1'h1;
                txFrame_q <= {1'h1, sendData, 1'h0};
                txBit_q   <= 4'h0;
                txCnt_q   <= 4'h0;
            end
        end else if (bitTick) begin
            txCnt_q <= txCnt_q + 4'h1;
            if (txCnt_q == 4'hf) begin
                txFrame_q <= {1'h1, txFrame_q[9:1]};
                txBit_q   <= txBit_q + 4'h1;
                if (txBit_q == 4'h9)
                    txBusy_q <= 1'h0;
            end
        end
    end
    assign line.serialPeerToDev = txFrame_q[0];
    assign sendReady = !txBusy_q;

    // receiver, centre sampled
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rxSync_q  <= 2'h3;
            rxBusy_q  <= 1'h0;
            rxBit_q   <= 4'h0;
            rxCnt_q   <= 4'h0;
            rxShift_q <= 8'h00;
            recvData  <= 8'h00;
            recvValid <= 1'h0;
        end else begin
            rxSync_q  <= {rxSync_q[0], line.serialDevToPeer};
            recvValid <= 1'h0;
            if (!rxBusy_q) begin
                if (!rxSync_q[1]) begin
                    rxBusy_q <= 1'h1;
                    rxCnt_q  <= 4'h8;
                    rxBit_q  <= 4'h0;
                end
            end else if (bitTick) begin
                rxCnt_q <= rxCnt_q + 4'h1;
                if (rxCnt_q == 4'hf) begin
                    rxBit_q <= rxBit_q + 4'h1;
                    if (rxBit_q == 4'h0 && rxSync_q[1])
                        rxBusy_q <= 1'h0;
                    else if (rxBit_q == 4'h9) begin
                        rxBusy_q  <= 1'h0;
                        recvData  <= rxShift_q;
                        recvValid <= 1'h1;
                    end else if (rxBit_q != 4'h0)
                        rxShift_q <= {rxSync_q[1], rxShift_q[7:1]};
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/pcu_pkg.sv ***
`default_nettype none
package pcu_pkg;
    localparam int OVS = 16;                  // sample clocks per bit
    localparam logic [4:0] MID = 5'h08;       // half bit
    localparam logic [4:0] FULL = 5'h10;      // one bit
    localparam logic [4:0] HALF_STOP = 5'h18; // one and a half bits
    localparam logic [3:0] LEN5 = 4'h5;       // base char length
    localparam logic [7:0] IDLE_BYTE = 8'h00;
    typedef enum logic [1:0] {LEN_5, LEN_6, LEN_7, LEN_8} pcu_len_e;
endpackage
`default_nettype wire
